//--- hdl/phy_mgmt_pkg.sv
/*
  Constants for the PHY test-mode and margin register block: management
  frame layout, register indexes, field positions and reset values.
  Assumes one 25 MHz clock and a clause-45 style management frame.
*/
package phy_mgmt_pkg;
  // Frame layout, counted in management clock bits
  localparam logic [5:0]  PREAMBLE_BITS   = 6'h20;   // Ones before start
  localparam logic [5:0]  HDR_BITS        = 6'h0E;   // Start, op, port, device
  localparam logic [5:0]  DATA_BITS       = 6'h10;   // Address or data word
  localparam logic [1:0]  FRAME_START     = 2'h0;    // Clause-45 start code
  localparam logic [1:0]  OP_ADDRESS      = 2'h0;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_READ_INC     = 2'h2;
  localparam logic [1:0]  OP_READ         = 2'h3;
  localparam logic [4:0]  DEVAD_PMA       = 5'h01;   // Physical-medium space
  // Register indexes in device space 1
  localparam logic [15:0] REG_TEST_MODE   = 16'h0084;
  localparam logic [15:0] REG_MARGIN_A    = 16'h0085;
  localparam logic [15:0] REG_MARGIN_B    = 16'h0086;
  localparam logic [15:0] REG_MARGIN_C    = 16'h0087;
  // Test-mode field positions
  localparam int          TM_HI_MSB       = 15;
  localparam int          TM_HI_LSB       = 13;
  localparam int          TONE_MSB        = 12;
  localparam int          TONE_LSB        = 10;
  localparam int          LP_MSB          = 9;
  localparam int          LP_LSB          = 8;
  localparam logic [15:0] TEST_MODE_RESET = 16'h0000;
  localparam logic [3:0]  TEST_MODE_LP_A  = 4'h8;    // Low-power mode, code 01
  localparam logic [3:0]  TEST_MODE_LP_B  = 4'h9;    // Low-power mode, code 10
  // Margin encoding: offset binary, 0.1 dB per step
  localparam logic [15:0] MARGIN_ZERO     = 16'h8000;
  localparam logic [15:0] MARGIN_SPAN     = 16'h007F; // 12.7 dB in 0.1 dB steps
  localparam logic [15:0] MARGIN_MAX      = MARGIN_ZERO + MARGIN_SPAN;
  localparam logic [15:0] MARGIN_MIN      = MARGIN_ZERO - MARGIN_SPAN;
  localparam int          NUM_CHAN        = 3;

  // Management frame receiver states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_TA   = 2'b10,
    ST_DATA = 2'b11
  } mgmt_state_t;
endpackage : phy_mgmt_pkg

//--- hdl/phy_test_mode_and_snr_margin_regs.sv
/*
  Test-mode control and per-channel margin registers of a twisted-pair PHY,
  reached over the serial management pins.
  Assumes mdc_i and mdio_i come from off-chip and are sampled here; the
  margin inputs come from on-chip logic on clk_i.
*/
`timescale 1ns/100ps
// What this block does
// - Registers at 0x84 upward, device space 1
// - Hi and low-power fields pick modes 1-9
// - Tone field picks dual tones 1-5
// - Each channel margin continuously updated, read-only
// - Margin offset-binary, 0x8000 is 0 dB, reset
// - Margin steps 0.1 dB, clamped to plus or minus 12.7 dB
module phy_test_mode_and_snr_margin_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00            // Port address strap
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        mdc_i,                   // Management clock pin
  input  wire logic        mdio_i,                  // Management data in
  output logic             mdio_o,                  // Management data out
  output logic             mdio_oe_o,               // High while driving
  input  wire logic [15:0] margin_chan_a_i,         // Measured margin A
  input  wire logic [15:0] margin_chan_b_i,         // Measured margin B
  input  wire logic [15:0] margin_chan_c_i,         // Measured margin C
  output logic [15:0]      transmit_test_mode_o,    // Whole control word
  output logic [3:0]       test_mode_o,             // 0 normal, else 1..9
  output logic [2:0]       transmit_dual_tone_o     // 0 reserved, else 1..5
);

  // Pin synchronisers; first stages feed only the second
  logic        mdc_s1_ff, mdc_s2_ff, mdc_s3_ff;
  logic        mdio_s1_ff, mdio_s2_ff;
  logic        mdc_rise;                            // One-cycle event
  // Frame receiver state
  mgmt_state_t st_ff, nxt_st;
  logic [5:0]  cnt_ff, nxt_cnt;                     // Bit counter
  logic [15:0] shf_ff, nxt_shf;                     // Shift register
  logic [1:0]  op_ff, nxt_op;                       // Frame opcode
  logic [15:0] addr_ff, nxt_addr;                   // Register index
  logic        out_ff, nxt_out;                     // Pin data
  logic        oe_ff, nxt_oe;                       // Pin enable
  logic [15:0] test_ff, nxt_test;                   // Test-mode register
  logic        wr_stb;                              // Data-frame write
  logic [15:0] wr_data;
  logic [13:0] hdr;
  logic [15:0] rd_data;
  // Decoded outputs
  logic [3:0]  mode_ff, nxt_mode;
  logic [2:0]  tone_ff, nxt_tone;
  // Margin storage, one word per channel
  logic [15:0] margin_in [NUM_CHAN];
  logic [15:0] margin_ff [NUM_CHAN];
  if (PHY_ADDR > 5'h1F) begin : g_bad_addr
    $error("PHY_ADDR out of range");
  end
  // Two flops per pin; a third on mdc only for edge detection
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mdc_s1_ff  <= 1'b0;
      mdc_s2_ff  <= 1'b0;
      mdc_s3_ff  <= 1'b0;
      mdio_s1_ff <= 1'b1;
      mdio_s2_ff <= 1'b1;
    end else begin
      mdc_s1_ff  <= mdc_i;
      mdc_s2_ff  <= mdc_s1_ff;
      mdc_s3_ff  <= mdc_s2_ff;
      mdio_s1_ff <= mdio_i;
      mdio_s2_ff <= mdio_s1_ff;
    end
  end
  // Data and clock share the same delay, so they stay aligned
  assign mdc_rise = mdc_s2_ff & ~mdc_s3_ff;
  assign hdr      = {shf_ff[12:0], mdio_s2_ff};
  assign wr_data  = {shf_ff[14:0], mdio_s2_ff};
  // Read mux; unmapped indexes in this space read zero
  always_comb begin
    case (addr_ff)
      REG_TEST_MODE: rd_data = test_ff;
      REG_MARGIN_A:  rd_data = margin_ff[0];
      REG_MARGIN_B:  rd_data = margin_ff[1];
      REG_MARGIN_C:  rd_data = margin_ff[2];
      default:       rd_data = 16'h0000;
    endcase
  end
  // Frame receiver next state; acts only on a sampled mdc rise
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_shf  = shf_ff;
    nxt_op   = op_ff;
    nxt_addr = addr_ff;
    nxt_out  = out_ff;
    nxt_oe   = oe_ff;
    wr_stb   = 1'b0;
    if (mdc_rise) begin
      case (st_ff)
        ST_IDLE: begin
          nxt_oe = 1'b0;
          if (mdio_s2_ff) begin
            // Saturate so long preambles still count
            if (cnt_ff != PREAMBLE_BITS) begin
              nxt_cnt = cnt_ff + 6'h01;
            end
          end else if (cnt_ff == PREAMBLE_BITS) begin
            nxt_st  = ST_HDR;
            nxt_cnt = 6'h01;
            nxt_shf = 16'h0000;
          end else begin
            nxt_cnt = 6'h00;
          end
        end
        ST_HDR: begin
          nxt_shf = wr_data;
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == HDR_BITS - 6'h01) begin
            nxt_cnt = 6'h00;
            nxt_op  = hdr[11:10];
            // answer only our port in device space 1
            if (hdr[13:12] == FRAME_START && hdr[9:5] == PHY_ADDR && hdr[4:0] == DEVAD_PMA) begin
              nxt_st = ST_TA;
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        ST_TA: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h00) begin
            // Second turnaround bit: drive zero on reads
            if (op_ff[1]) begin
              nxt_oe  = 1'b1;
              nxt_out = 1'b0;
              // reads only copy, nothing is cleared
              nxt_shf = rd_data;
            end
          end else begin
            nxt_st  = ST_DATA;
            nxt_cnt = 6'h00;
            nxt_out = shf_ff[15];
          end
        end
        ST_DATA: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (op_ff[1]) begin
            nxt_shf = {shf_ff[14:0], 1'b0};
            nxt_out = shf_ff[14];
          end else begin
            nxt_shf = wr_data;
          end
          if (cnt_ff == DATA_BITS - 6'h01) begin
            nxt_st  = ST_IDLE;
            nxt_cnt = 6'h00;
            nxt_oe  = 1'b0;
            case (op_ff)
              OP_ADDRESS:  nxt_addr = wr_data;
              OP_WRITE:    wr_stb = 1'b1;
              OP_READ_INC: nxt_addr = addr_ff + 16'h0001;
              default:     nxt_addr = addr_ff;
            endcase
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end
  // Test-mode register and its decoded fields
  always_comb begin
    nxt_test = test_ff;
    // only the test-mode index accepts writes
    if (wr_stb && addr_ff == REG_TEST_MODE) begin
      // low byte stored as the host writes it
      nxt_test = wr_data;
    end
    // hi field modes 1-7, low-power field 8-9
    nxt_mode = 4'h0;
    if (test_ff[TM_HI_MSB:TM_HI_LSB] != 3'h0) begin
      if (test_ff[LP_MSB:LP_LSB] == 2'h0) begin
        nxt_mode = {1'b0, test_ff[TM_HI_MSB:TM_HI_LSB]};
      end
    end else begin
      case (test_ff[LP_MSB:LP_LSB])
        2'h1:    nxt_mode = TEST_MODE_LP_A;
        2'h2:    nxt_mode = TEST_MODE_LP_B;
        default: nxt_mode = 4'h0;
      endcase
    end
    // tone code to tone number, reserved gives zero
    case (test_ff[TONE_MSB:TONE_LSB])
      3'h1:    nxt_tone = 3'h1;
      3'h2:    nxt_tone = 3'h2;
      3'h4:    nxt_tone = 3'h3;
      3'h5:    nxt_tone = 3'h4;
      3'h6:    nxt_tone = 3'h5;
      default: nxt_tone = 3'h0;
    endcase
  end
  // Register all management state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff   <= ST_IDLE;
      cnt_ff  <= 6'h00;
      shf_ff  <= 16'h0000;
      op_ff   <= OP_ADDRESS;
      addr_ff <= 16'h0000;
      out_ff  <= 1'b0;
      oe_ff   <= 1'b0;
      test_ff <= TEST_MODE_RESET;
      mode_ff <= 4'h0;
      tone_ff <= 3'h0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      shf_ff  <= nxt_shf;
      op_ff   <= nxt_op;
      addr_ff <= nxt_addr;
      out_ff  <= nxt_out;
      oe_ff   <= nxt_oe;
      test_ff <= nxt_test;
      mode_ff <= nxt_mode;
      tone_ff <= nxt_tone;
    end
  end
  assign mdio_o               = out_ff;
  assign mdio_oe_o            = oe_ff;
  assign transmit_test_mode_o = test_ff;
  assign test_mode_o          = mode_ff;
  assign transmit_dual_tone_o = tone_ff;
  assign margin_in[0] = margin_chan_a_i;
  assign margin_in[1] = margin_chan_b_i;
  assign margin_in[2] = margin_chan_c_i;
  // Margin capture per channel; clamping keeps odd codes off the bus
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_margin
    logic [15:0] nxt_margin;
    always_comb begin
      if (margin_in[ch] > MARGIN_MAX) begin
        nxt_margin = MARGIN_MAX;
      end else if (margin_in[ch] < MARGIN_MIN) begin
        nxt_margin = MARGIN_MIN;
      end else begin
        nxt_margin = margin_in[ch];
      end
    end
    // refreshed every clock; zero dB at reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        margin_ff[ch] <= MARGIN_ZERO;
      end else begin
        margin_ff[ch] <= nxt_margin;
      end
    end
  end
  // Checks on the behaviour above
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_MARGIN_RESET: assert property ($rose(rst_b_i) |-> margin_ff[0] == MARGIN_ZERO)
    else $error("margin A not zero dB after reset");
  AST_MARGIN_TRACK: assert property (
    (margin_chan_b_i <= MARGIN_MAX && margin_chan_b_i >= MARGIN_MIN) |=> margin_ff[1] == $past(margin_chan_b_i))
    else $error("margin B did not follow input");
  AST_MARGIN_SPAN: assert property (##1 (margin_ff[2] <= MARGIN_MAX && margin_ff[2] >= MARGIN_MIN))
    else $error("margin C outside span");
  AST_MODE_LP: assert property (
    (test_ff[TM_HI_MSB:TM_HI_LSB] == 3'h0 && test_ff[LP_MSB:LP_LSB] == 2'h2) |=> test_mode_o == 4'h9)
    else $error("low-power test mode 9 not selected");
  AST_MODE_HI: assert property (
    (test_ff[TM_HI_MSB:TM_HI_LSB] == 3'h5 && test_ff[LP_MSB:LP_LSB] == 2'h0) |=> test_mode_o == 4'h5)
    else $error("test mode 5 not selected");
  AST_TONE_RSVD: assert property (
    (test_ff[TONE_MSB:TONE_LSB] == 3'h3 || test_ff[TONE_MSB:TONE_LSB] == 3'h7) |=> transmit_dual_tone_o == 3'h0)
    else $error("reserved tone code gave a tone");
  AST_TONE_THREE: assert property (test_ff[TONE_MSB:TONE_LSB] == 3'h4 |=> transmit_dual_tone_o == 3'h3)
    else $error("tone code 100 is not tone 3");
  AST_RO_WRITE: assert property ((wr_stb && addr_ff != REG_TEST_MODE) |=> $stable(test_ff))
    else $error("write to other index changed test register");
  AST_READ_DRIVE: assert property ((st_ff == ST_DATA && op_ff[1]) |-> mdio_oe_o)
    else $error("read data not driven");
  AST_DRIVE_END: assert property (
    (mdc_rise && st_ff == ST_DATA && cnt_ff == DATA_BITS - 6'h01) |=> !mdio_oe_o [*2])
    else $error("pin still driven after frame");

  COV_WRITE_TEST: cover property (wr_stb && addr_ff == REG_TEST_MODE);
  COV_READ_MARGIN: cover property (st_ff == ST_DATA && op_ff == OP_READ && addr_ff == REG_MARGIN_A);
  COV_READ_INC: cover property (st_ff == ST_DATA && op_ff == OP_READ_INC);
  COV_MODE_NINE: cover property (test_mode_o == 4'h9);

endmodule : phy_test_mode_and_snr_margin_regs

//--- test/mgmt_host_model.sv
/*
  Station management host model: drives management frames on the pins.
  Assumes a pulled-up data line resolved by the bench, clk_i at 25 MHz.
*/
`timescale 1ns/100ps
module mgmt_host_model
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PORT = 5'h00       // Target port address
) (
  input  wire logic clk_i,
  input  wire logic mdio_pin_i,            // Resolved data line
  output logic      mdc_o,                 // Stands low between frames
  output logic      mdio_d_o,
  output logic      mdio_oe_o              // High while host drives
);
  localparam int HALF = 8;                 // Clocks per half bit, slow enough for the sync
  initial begin
    mdc_o = 1'b0;
    mdio_d_o = 1'b0;
    mdio_oe_o = 1'b0;
  end
  // One bit: set data while low, sample just before the rise
  task automatic bit_cyc(input logic drv, input logic d, output logic s);
    @(negedge clk_i);
    mdc_o = 1'b0;
    mdio_oe_o = drv;
    mdio_d_o = d;
    repeat (HALF) @(negedge clk_i);
    s = mdio_pin_i;
    mdc_o = 1'b1;
    repeat (HALF - 1) @(negedge clk_i);
  endtask : bit_cyc
  task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] w;
    logic        s;
    w = {32'hFFFFFFFF, FRAME_START, op, port, DEVAD_PMA, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      // Released during turnaround and data of reads
      bit_cyc(!(op[1] && i < 18), w[i], s);
      if (i < 16) rd[i] = s;
    end
    @(negedge clk_i);
    mdc_o = 1'b0;
    mdio_oe_o = 1'b0;
    repeat (2 * HALF) @(negedge clk_i);
  endtask : frame
  task automatic addr(input logic [15:0] a);
    logic [15:0] r;
    frame(OP_ADDRESS, PORT, a, r);
  endtask : addr
  task automatic wr(input logic [15:0] d);
    logic [15:0] r;
    frame(OP_WRITE, PORT, d, r);
  endtask : wr
  task automatic rd(input logic [1:0] op, output logic [15:0] d);
    frame(op, PORT, 16'h0000, d);
  endtask : rd
  task automatic rmw(input logic [7:0] hi_byte);
    logic [15:0] old;
    rd(OP_READ, old);
    wr({hi_byte, old[7:0]});
  endtask : rmw
endmodule : mgmt_host_model

//--- test/tb.sv
/*
  Self-checking bench for the test-mode and margin registers.
  Assumes the host model above and a pull-up on the data line.
*/
`timescale 1ns/100ps
module tb;
  import phy_mgmt_pkg::*;
  localparam logic [4:0] PORT = 5'h03;    // Nonzero to exercise port match
  logic        clk = 1'b0;
  logic        rst_b;
  logic        mdc, h_d, h_oe, d_o, d_oe, pin;
  logic [15:0] ma, mb, mc, tword, rv, d;
  logic [3:0]  tmode;
  logic [2:0]  tone;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [15:0] lpw [4] = '{16'h05A5, 16'h0AA5, 16'h31A5, 16'h17A5};
  always #20 clk = ~clk;
  // Pull-up wins when nobody drives
  assign pin = d_oe ? d_o : (h_oe ? h_d : 1'b1);
  phy_test_mode_and_snr_margin_regs #(.PHY_ADDR(PORT)) u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .mdc_i(mdc), .mdio_i(pin), .mdio_o(d_o), .mdio_oe_o(d_oe),
    .margin_chan_a_i(ma), .margin_chan_b_i(mb), .margin_chan_c_i(mc),
    .transmit_test_mode_o(tword), .test_mode_o(tmode), .transmit_dual_tone_o(tone));
  mgmt_host_model #(.PORT(PORT)) u_host (
    .clk_i(clk), .mdio_pin_i(pin), .mdc_o(mdc), .mdio_d_o(h_d), .mdio_oe_o(h_oe));
  function automatic logic [15:0] exp_mode(input logic [15:0] w);
    if (w[9:8] == 2'b00) return 16'(w[15:13]);
    if (w[15:13] == 3'h0) return (w[9:8] == 2'b01) ? 16'h0008 : (w[9:8] == 2'b10) ? 16'h0009 : 16'h0000;
    return 16'h0000;
  endfunction : exp_mode
  function automatic logic [15:0] exp_tone(input logic [2:0] f);
    case (f)
      3'h1, 3'h2: return 16'(f);
      3'h4, 3'h5, 3'h6: return 16'(f - 3'h1);
      default: return 16'h0000;   // Reserved codes
    endcase
  endfunction : exp_tone
  // Out-of-range margins saturate at plus or minus 12.7 dB
  function automatic logic [15:0] clamp(input logic [15:0] v);
    return (v > 16'h807F) ? 16'h807F : (v < 16'h7F81) ? 16'h7F81 : v;
  endfunction : clamp
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // Hang guard, about 57 frames of 1041 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    rst_b = 1'b0;
    ma = 16'h8000;
    mb = 16'h8000;
    mc = 16'h8000;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk("test_word", TEST_MODE_RESET, tword);
    chk("test_mode", 16'h0000, 16'(tmode));
    u_host.addr(REG_MARGIN_A);
    for (int i = 0; i < 3; i++) begin
      u_host.rd(OP_READ_INC, rv);
      chk("margin_reset", 16'h8000, rv);
    end
    ma = 16'h807F;
    mb = 16'h0000;
    mc = 16'hFFFF;
    u_host.addr(REG_MARGIN_A);
    u_host.rd(OP_READ_INC, rv);
    chk("margin_a", clamp(ma), rv);
    u_host.rd(OP_READ_INC, rv);
    chk("margin_b", clamp(mb), rv);
    u_host.rd(OP_READ_INC, rv);
    chk("margin_c", clamp(mc), rv);
    // Write to a read-only margin: value kept, test word untouched
    u_host.addr(REG_MARGIN_B);
    u_host.wr(16'h1234);
    u_host.rd(OP_READ, rv);
    chk("margin_b_kept", 16'h7F81, rv);
    chk("ro_write", TEST_MODE_RESET, tword);
    // Then a fresh measurement shows through
    mb = 16'h7FF6;
    u_host.rd(OP_READ, rv);
    chk("margin_b_live", 16'h7FF6, rv);
    u_host.addr(REG_TEST_MODE);
    for (int i = 0; i < 12; i++) begin
      d = (i < 8) ? {i[2:0], i[2:0], 2'b00, 8'h5A} : lpw[i - 8];
      u_host.wr(d);
      chk("test_word", d, tword);
      chk("test_mode", exp_mode(d), 16'(tmode));
      chk("dual_tone", exp_tone(d[12:10]), 16'(tone));
    end
    // Frame to another port must be ignored
    u_host.frame(OP_WRITE, 5'h1F, 16'hE000, rv);
    chk("other_port", 16'h17A5, tword);
    u_host.rmw(8'h44);
    chk("rmw_word", 16'h44A5, tword);
    u_host.rd(OP_READ, rv);
    chk("readback", 16'h44A5, rv);
    u_host.addr(16'h0090);
    u_host.rd(OP_READ, rv);
    chk("unmapped", 16'h0000, rv);
    report_and_stop();
  end
endmodule : tb
